// ==== src/mpls_pkg.sv ====
package mpls_pkg;

    // Register byte offsets
    localparam logic [12:0] TX_POLL_OFS = 13'h1004;
    localparam logic [12:0] RX_POLL_OFS = 13'h1008;
    localparam logic [12:0] RX_BASE_OFS = 13'h100c;
    localparam logic [12:0] TX_BASE_OFS = 13'h1010;
    localparam logic [12:0] STATUS_OFS = 13'h1014;
    localparam logic [12:0] IRQ_EN_OFS = 13'h101c;

    localparam logic [31:0] REG_RESET = 32'h0000_0000;
    localparam logic [16:0] IRQ_EN_RESET = 17'h0_0000;

    // Sticky flag positions
    localparam int FLG_TX_DONE = 0;
    localparam int FLG_TX_STOPPED = 1;
    localparam int FLG_TX_NO_DESC = 2;
    localparam int FLG_JABBER = 3;
    localparam int FLG_OVERFLOW = 4;
    localparam int FLG_UNDERFLOW = 5;
    localparam int FLG_RX_DONE = 6;
    localparam int FLG_RX_NO_DESC = 7;
    localparam int FLG_RX_STOPPED = 8;
    localparam int FLG_WATCHDOG = 9;
    localparam int FLG_EARLY_TX = 10;
    localparam int FLG_FATAL_BUS = 13;
    localparam int FLG_EARLY_RX = 14;
    localparam int FLG_ABNORMAL = 15;
    localparam int FLG_NORMAL = 16;
    localparam int FLAG_W = 17;

    localparam logic [16:0] NORMAL_MASK = 17'h0_4045;
    localparam logic [16:0] ABNORMAL_MASK = 17'h0_27ba;
    localparam logic [16:0] W1C_MASK = 17'h1_e7ff;

    // Status level fields
    localparam int ST_IDLE_BIT = 30;
    localparam int ST_TS_BIT = 29;
    localparam int ST_PM_BIT = 28;
    localparam int ST_MMC_BIT = 27;
    localparam int ST_EB_LSB = 23;
    localparam int ST_TXS_LSB = 20;
    localparam int ST_RXS_LSB = 17;

    // Process state codes
    localparam logic [2:0] TXS_STOPPED = 3'h0;
    localparam logic [2:0] TXS_FETCH = 3'h1;
    localparam logic [2:0] TXS_READ = 3'h3;
    localparam logic [2:0] TXS_SUSPENDED = 3'h6;
    localparam logic [2:0] RXS_STOPPED = 3'h0;
    localparam logic [2:0] RXS_FETCH = 3'h1;
    localparam logic [2:0] RXS_WAIT = 3'h3;
    localparam logic [2:0] RXS_SUSPENDED = 3'h4;

    typedef enum logic [3:0] {
        TX_STOP = 4'b0001,
        TX_FETCH = 4'b0010,
        TX_RUN = 4'b0100,
        TX_SUSP = 4'b1000
    } mpls_tx_e;

    typedef enum logic [3:0] {
        RX_STOP = 4'b0001,
        RX_FETCH = 4'b0010,
        RX_WAIT = 4'b0100,
        RX_SUSP = 4'b1000
    } mpls_rx_e;

    typedef struct packed {
        mpls_tx_e tx_st;
        mpls_rx_e rx_st;
        logic tx_poll;
        logic rx_poll;
        logic [29:0] tx_base;
        logic [29:0] rx_base;
        logic [31:0] tx_ptr;
        logic [31:0] rx_ptr;
        logic [16:0] irq_en;
        logic [2:0] bus_err_kind;
        logic waitreq;
        logic [31:0] rdata;
        logic tx_fetch;
        logic rx_fetch;
        logic main_irq;
        logic idle_irq;
        logic wake_irq;
    } mpls_state_s;

endpackage

// ==== src/mpls_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpls_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } mpls_sync_s;

    mpls_sync_s q;
    mpls_sync_s d;

    // First stage feeds only the second stage
    always_comb begin
        d.meta = async_in;
        d.stable = q.meta;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sync_out = q.stable;
endmodule
`default_nettype wire

// ==== src/mpls_flags.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpls_flags #(
    parameter int W = 17
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Hardware set and software clear
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    output logic [W-1:0] flags_out
);
    typedef struct packed {
        logic [W-1:0] flags;
    } mpls_flags_s;

    mpls_flags_s q;
    mpls_flags_s d;

    // A set in the clearing cycle wins so no event is lost
    always_comb begin
        d.flags = (q.flags & ~clr_in) | set_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign flags_out = q.flags;
endmodule
`default_nettype wire

// ==== src/mpls_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Tx poll write refetches; host-owned sets bit2
// - Tx suspends on underflow/no descriptor; poll clears
// - Rx poll write refetches; host-owned sets bit7
// - Rx suspends only for missing descriptor
// - Rx base bits 31:2; bits 1:0 read zero
// - List addresses forced word aligned
// - Status read harmless; write one clears
// - Each event flag bit, bit10 included, maskable by enable register; summary bits 16:15 are not
// - Bit30 mirrors idle event, drives idle irq
// - Bit29 mirrors timestamp event, drives main irq
// - Bit28 mirrors wake event, drives two irqs
// - Wake event synchronised before use
// - Bit27 mirrors counter event, drives main irq
// - Bus error kind valid with fatal flag
// - Tx process state coded in bits 22:20
// - Normal summary: OR of enabled normal flags
// - Abnormal summary: OR of enabled error flags
module mpls_top (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Avalon-MM slave
    input wire logic [12:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    // Transmit engine
    input wire logic tx_run_in,
    input wire logic tx_desc_ready_in,
    input wire logic tx_desc_owned_in,
    input wire logic [31:0] tx_next_ptr_in,
    input wire logic tx_frame_done_in,
    input wire logic tx_underflow_in,
    input wire logic tx_jabber_in,
    input wire logic tx_early_in,
    output logic tx_fetch_out,
    output logic [31:0] tx_desc_addr_out,
    // Receive engine
    input wire logic rx_run_in,
    input wire logic rx_desc_ready_in,
    input wire logic rx_desc_owned_in,
    input wire logic [31:0] rx_next_ptr_in,
    input wire logic rx_frame_done_in,
    input wire logic rx_frame_seen_in,
    input wire logic rx_overflow_in,
    input wire logic rx_watchdog_in,
    input wire logic rx_early_in,
    output logic rx_fetch_out,
    output logic [31:0] rx_desc_addr_out,
    // Bus error report
    input wire logic bus_error_in,
    input wire logic [2:0] bus_error_kind_in,
    // Event sources
    input wire logic idle_event_in,
    input wire logic ts_event_in,
    input wire logic counter_event_in,
    input wire logic power_mgmt_event_in,
    // Interrupt outputs
    output logic main_irq_out,
    output logic idle_irq_out,
    output logic wake_irq_out
);
    mpls_pkg::mpls_state_s q;
    mpls_pkg::mpls_state_s d;
    logic [16:0] flag_set;
    logic [16:0] flag_clr;
    logic [16:0] flags;
    logic pm_sync;
    logic acc;
    logic take;
    logic [12:0] word_addr;
    logic [31:0] wmask;
    logic [31:0] status_word;
    logic [31:0] base_new;

    // Wake source comes from the receive clock domain
    mpls_sync #(
        .W(1)
    ) u_pm_sync (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .async_in(power_mgmt_event_in),
        .sync_out(pm_sync)
    );

    mpls_flags #(
        .W(mpls_pkg::FLAG_W)
    ) u_flags (
        .sys_clk_in(sys_clk_in),
        .rst_in(rst_in),
        .set_in(flag_set),
        .clr_in(flag_clr),
        .flags_out(flags)
    );

    function automatic logic [2:0] tx_code(input mpls_pkg::mpls_tx_e st);
        case (st)
            mpls_pkg::TX_FETCH: tx_code = mpls_pkg::TXS_FETCH;
            mpls_pkg::TX_RUN: tx_code = mpls_pkg::TXS_READ;
            mpls_pkg::TX_SUSP: tx_code = mpls_pkg::TXS_SUSPENDED;
            default: tx_code = mpls_pkg::TXS_STOPPED;
        endcase
    endfunction

    function automatic logic [2:0] rx_code(input mpls_pkg::mpls_rx_e st);
        case (st)
            mpls_pkg::RX_FETCH: rx_code = mpls_pkg::RXS_FETCH;
            mpls_pkg::RX_WAIT: rx_code = mpls_pkg::RXS_WAIT;
            mpls_pkg::RX_SUSP: rx_code = mpls_pkg::RXS_SUSPENDED;
            default: rx_code = mpls_pkg::RXS_STOPPED;
        endcase
    endfunction

    always_comb begin
        status_word = mpls_pkg::REG_RESET;
        status_word[16:0] = flags;
        status_word[mpls_pkg::ST_IDLE_BIT] = idle_event_in;
        status_word[mpls_pkg::ST_TS_BIT] = ts_event_in;
        status_word[mpls_pkg::ST_PM_BIT] = pm_sync;
        status_word[mpls_pkg::ST_MMC_BIT] = counter_event_in;
        // Kind valid only while the fatal flag stands
        status_word[mpls_pkg::ST_EB_LSB +: 3] = q.bus_err_kind;
        status_word[mpls_pkg::ST_TXS_LSB +: 3] = tx_code(q.tx_st);
        status_word[mpls_pkg::ST_RXS_LSB +: 3] = rx_code(q.rx_st);
    end

    always_comb begin
        d = q;
        flag_set = '0;
        flag_clr = '0;
        acc = avs_read_in | avs_write_in;
        take = acc && !q.waitreq;
        word_addr = {avs_address_in[12:2], 2'b00};
        wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
            {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
        base_new = avs_writedata_in & wmask;

        // One wait cycle; answer stands one cycle
        d.waitreq = 1'b1;
        if (acc && q.waitreq) begin
            d.waitreq = 1'b0;
            case (word_addr)
                mpls_pkg::RX_BASE_OFS: d.rdata = {q.rx_base, 2'b00};
                mpls_pkg::TX_BASE_OFS: d.rdata = {q.tx_base, 2'b00};
                mpls_pkg::STATUS_OFS: d.rdata = status_word;
                mpls_pkg::IRQ_EN_OFS: d.rdata = {15'h0000, q.irq_en};
                default: d.rdata = mpls_pkg::REG_RESET;
            endcase
        end

        case (q.tx_st)
            mpls_pkg::TX_STOP: begin
                if (tx_run_in) begin
                    d.tx_ptr = {q.tx_base, 2'b00};
                    d.tx_st = mpls_pkg::TX_FETCH;
                end
            end
            mpls_pkg::TX_FETCH: begin
                d.tx_poll = 1'b0;
                if (tx_desc_ready_in) begin
                    if (tx_desc_owned_in) begin
                        d.tx_st = mpls_pkg::TX_RUN;
                    end else begin
                        d.tx_st = mpls_pkg::TX_SUSP;
                        flag_set[mpls_pkg::FLG_TX_NO_DESC] = 1'b1;
                    end
                end
            end
            mpls_pkg::TX_RUN: begin
                if (tx_underflow_in) begin
                    d.tx_st = mpls_pkg::TX_SUSP;
                    flag_set[mpls_pkg::FLG_UNDERFLOW] = 1'b1;
                end else if (tx_frame_done_in) begin
                    flag_set[mpls_pkg::FLG_TX_DONE] = 1'b1;
                    d.tx_ptr = {tx_next_ptr_in[31:2], 2'b00};
                    d.tx_st = mpls_pkg::TX_FETCH;
                end
            end
            mpls_pkg::TX_SUSP: begin
                if (q.tx_poll) begin
                    d.tx_st = mpls_pkg::TX_FETCH;
                end
            end
            default: d.tx_st = mpls_pkg::TX_STOP;
        endcase
        if (!tx_run_in && q.tx_st != mpls_pkg::TX_STOP) begin
            d.tx_st = mpls_pkg::TX_STOP;
            flag_set[mpls_pkg::FLG_TX_STOPPED] = 1'b1;
        end

        // Receive process; only a missing descriptor suspends it
        case (q.rx_st)
            mpls_pkg::RX_STOP: begin
                if (rx_run_in) begin
                    d.rx_ptr = {q.rx_base, 2'b00};
                    d.rx_st = mpls_pkg::RX_FETCH;
                end
            end
            mpls_pkg::RX_FETCH: begin
                d.rx_poll = 1'b0;
                if (rx_desc_ready_in) begin
                    if (rx_desc_owned_in) begin
                        d.rx_st = mpls_pkg::RX_WAIT;
                    end else begin
                        d.rx_st = mpls_pkg::RX_SUSP;
                        flag_set[mpls_pkg::FLG_RX_NO_DESC] = 1'b1;
                    end
                end
            end
            mpls_pkg::RX_WAIT: begin
                if (rx_frame_done_in) begin
                    flag_set[mpls_pkg::FLG_RX_DONE] = 1'b1;
                    flag_clr[mpls_pkg::FLG_EARLY_RX] = 1'b1;
                    d.rx_ptr = {rx_next_ptr_in[31:2], 2'b00};
                    d.rx_st = mpls_pkg::RX_FETCH;
                end
            end
            mpls_pkg::RX_SUSP: begin
                // A new frame also resumes without a poll
                if (q.rx_poll || rx_frame_seen_in) begin
                    d.rx_st = mpls_pkg::RX_FETCH;
                end
            end
            default: d.rx_st = mpls_pkg::RX_STOP;
        endcase
        if (!rx_run_in && q.rx_st != mpls_pkg::RX_STOP) begin
            d.rx_st = mpls_pkg::RX_STOP;
            flag_set[mpls_pkg::FLG_RX_STOPPED] = 1'b1;
        end

        flag_set[mpls_pkg::FLG_JABBER] = tx_jabber_in;
        flag_set[mpls_pkg::FLG_OVERFLOW] = rx_overflow_in;
        flag_set[mpls_pkg::FLG_WATCHDOG] = rx_watchdog_in;
        flag_set[mpls_pkg::FLG_EARLY_TX] = tx_early_in;
        flag_set[mpls_pkg::FLG_EARLY_RX] = rx_early_in;
        flag_set[mpls_pkg::FLG_FATAL_BUS] = bus_error_in;
        if (bus_error_in) begin
            d.bus_err_kind = bus_error_kind_in;
        end
        flag_set[mpls_pkg::FLG_NORMAL] =
            |(flags & mpls_pkg::NORMAL_MASK & q.irq_en);
        flag_set[mpls_pkg::FLG_ABNORMAL] =
            |(flags & mpls_pkg::ABNORMAL_MASK & q.irq_en);

        // Register writes; poll set after the fetch clear so it wins
        if (take && avs_write_in) begin
            case (word_addr)
                mpls_pkg::TX_POLL_OFS: d.tx_poll = 1'b1;
                mpls_pkg::RX_POLL_OFS: d.rx_poll = 1'b1;
                mpls_pkg::RX_BASE_OFS: begin
                    base_new = ({q.rx_base, 2'b00} & ~wmask) | base_new;
                    d.rx_base = base_new[31:2];
                end
                mpls_pkg::TX_BASE_OFS: begin
                    base_new = ({q.tx_base, 2'b00} & ~wmask) | base_new;
                    d.tx_base = base_new[31:2];
                end
                mpls_pkg::STATUS_OFS: begin
                    // Upper bits are read only
                    flag_clr = flag_clr | (avs_writedata_in[16:0]
                        & wmask[16:0] & mpls_pkg::W1C_MASK);
                end
                mpls_pkg::IRQ_EN_OFS: begin
                    d.irq_en = (q.irq_en & ~wmask[16:0])
                        | (avs_writedata_in[16:0] & wmask[16:0]);
                end
                default: d.irq_en = q.irq_en;
            endcase
        end

        // Fatal bus error stops descriptor fetches
        d.tx_fetch = (d.tx_st == mpls_pkg::TX_FETCH)
            && !flags[mpls_pkg::FLG_FATAL_BUS];
        d.rx_fetch = (d.rx_st == mpls_pkg::RX_FETCH)
            && !flags[mpls_pkg::FLG_FATAL_BUS];

        d.idle_irq = idle_event_in;
        d.wake_irq = pm_sync;
        d.main_irq = flags[mpls_pkg::FLG_NORMAL]
            | flags[mpls_pkg::FLG_ABNORMAL] | ts_event_in | pm_sync
            | counter_event_in;
    end

    always_ff @(posedge sys_clk_in) begin
        if (rst_in) begin
            q.tx_st <= mpls_pkg::TX_STOP;
            q.rx_st <= mpls_pkg::RX_STOP;
            q.tx_poll <= 1'b0;
            q.rx_poll <= 1'b0;
            q.tx_base <= mpls_pkg::REG_RESET[31:2];
            q.rx_base <= mpls_pkg::REG_RESET[31:2];
            q.tx_ptr <= mpls_pkg::REG_RESET;
            q.rx_ptr <= mpls_pkg::REG_RESET;
            q.irq_en <= mpls_pkg::IRQ_EN_RESET;
            q.bus_err_kind <= 3'h0;
            q.waitreq <= 1'b1;
            q.rdata <= mpls_pkg::REG_RESET;
            q.tx_fetch <= 1'b0;
            q.rx_fetch <= 1'b0;
            q.main_irq <= 1'b0;
            q.idle_irq <= 1'b0;
            q.wake_irq <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign avs_readdata_out = q.rdata;
    assign avs_waitrequest_out = q.waitreq;
    assign tx_fetch_out = q.tx_fetch;
    assign tx_desc_addr_out = q.tx_ptr;
    assign rx_fetch_out = q.rx_fetch;
    assign rx_desc_addr_out = q.rx_ptr;
    assign main_irq_out = q.main_irq;
    assign idle_irq_out = q.idle_irq;
    assign wake_irq_out = q.wake_irq;
endmodule
`default_nettype wire

// ==== bench/mpls_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpls_chk (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Descriptor fetch
    input wire logic tx_run_in,
    input wire logic tx_desc_ready_in,
    input wire logic tx_fetch_out,
    input wire logic [31:0] tx_desc_addr_out,
    input wire logic rx_run_in,
    input wire logic rx_desc_ready_in,
    input wire logic rx_fetch_out,
    input wire logic [31:0] rx_desc_addr_out,
    input wire logic bus_error_in,
    // Events and interrupts
    input wire logic idle_event_in,
    input wire logic ts_event_in,
    input wire logic counter_event_in,
    input wire logic power_mgmt_event_in,
    input wire logic main_irq_out,
    input wire logic idle_irq_out,
    input wire logic wake_irq_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    tx_fetch_end_a: assert property (
        tx_fetch_out && tx_desc_ready_in |=> !tx_fetch_out)
        else $error("tx fetch held up");
    rx_fetch_end_a: assert property (
        rx_fetch_out && rx_desc_ready_in |=> !rx_fetch_out)
        else $error("rx fetch held up");
    // Fatal flag gates fetch, so skip errors
    tx_fetch_hold_a: assert property (
        tx_fetch_out && !tx_desc_ready_in && tx_run_in && !bus_error_in
        && !$past(bus_error_in) |=> tx_fetch_out)
        else $error("tx fetch dropped");
    rx_fetch_hold_a: assert property (
        rx_fetch_out && !rx_desc_ready_in && rx_run_in && !bus_error_in
        && !$past(bus_error_in) |=> rx_fetch_out)
        else $error("rx fetch dropped");
    desc_align_a: assert property (
        tx_desc_addr_out[1:0] == 2'b00 && rx_desc_addr_out[1:0] == 2'b00)
        else $error("address unaligned");
    idle_irq_on_a: assert property (
        idle_event_in [*3] |-> idle_irq_out)
        else $error("idle irq missing");
    idle_irq_off_a: assert property (
        !idle_event_in [*3] |-> !idle_irq_out)
        else $error("idle irq stray");
    ts_main_irq_a: assert property (
        ts_event_in [*3] |-> main_irq_out)
        else $error("ts irq missing");
    counter_main_irq_a: assert property (
        counter_event_in [*3] |-> main_irq_out)
        else $error("counter irq missing");
    wake_both_irq_a: assert property (
        power_mgmt_event_in [*5] |-> wake_irq_out && main_irq_out)
        else $error("wake irqs missing");
    wake_clear_a: assert property (
        !power_mgmt_event_in [*5] |-> !wake_irq_out)
        else $error("wake irq stuck");

    cover property (tx_fetch_out && tx_desc_ready_in);
    cover property (rx_fetch_out && rx_desc_ready_in);
    cover property (wake_irq_out);
endmodule
bind mpls_top mpls_chk u_mpls_chk (.sys_clk_in, .rst_in, .tx_run_in,
    .tx_desc_ready_in, .tx_fetch_out, .tx_desc_addr_out, .rx_run_in,
    .rx_desc_ready_in, .rx_fetch_out, .rx_desc_addr_out, .bus_error_in,
    .idle_event_in, .ts_event_in, .counter_event_in, .power_mgmt_event_in,
    .main_irq_out, .idle_irq_out, .wake_irq_out);
`default_nettype wire

// ==== bench/mpls_desc_mem.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpls_desc_mem (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_in,
    // Fetch request and bench controls
    input wire logic fetch_in,
    input wire logic owned_in,
    input wire logic [3:0] lag_in,
    // Answer
    output logic ready_out,
    output logic owned_out
);
    logic [3:0] cnt_q;
    always_ff @(posedge sys_clk_in) begin
        // Owner bit is junk outside the answer cycle
        owned_out <= !owned_out;
        if (rst_in || !fetch_in || ready_out) begin
            cnt_q <= 4'h0;
            ready_out <= 1'b0;
        end else if (cnt_q >= lag_in) begin
            ready_out <= 1'b1;
            owned_out <= owned_in;
        end else begin
            cnt_q <= cnt_q + 4'h1;
        end
        if (rst_in) begin
            owned_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== bench/mpls_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module mpls_tb_top;
    localparam logic [12:0] ST = mpls_pkg::STATUS_OFS;
    localparam logic [12:0] EN = mpls_pkg::IRQ_EN_OFS;
    localparam logic [12:0] OFS[6] = '{mpls_pkg::TX_POLL_OFS,
        mpls_pkg::RX_POLL_OFS, mpls_pkg::RX_BASE_OFS,
        mpls_pkg::TX_BASE_OFS, ST, EN};
    localparam int FB[7] = '{0, 3, 10, 6, 4, 9, 14};
    localparam int EVB[4] = '{30, 29, 27, 28};
    localparam logic [2:0] EVI[4] = '{3'h4, 3'h2, 3'h2, 3'h3};
    logic sys_clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [12:0] avs_address_in = 13'h0000;
    logic avs_read_in = 1'b0, avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [3:0] avs_byteenable_in = 4'hf;
    logic tx_run_in = 1'b0, rx_run_in = 1'b0;
    logic tx_own = 1'b0, rx_own = 1'b0;
    logic [3:0] lag = 4'h0;
    logic [31:0] tx_next_ptr_in = 32'h0000_2003;
    logic [31:0] rx_next_ptr_in = 32'h0000_3000;
    logic [8:0] pl = 9'h000;
    logic [3:0] ev = 4'h0;
    logic bus_error_in = 1'b0;
    logic [2:0] bus_error_kind_in = 3'h0;
    logic [31:0] q;
    int err_count = 0, total_checks = 0;
    wire logic [31:0] avs_readdata_out, tx_desc_addr_out, rx_desc_addr_out;
    wire logic avs_waitrequest_out, tx_fetch_out, rx_fetch_out;
    wire logic main_irq_out, idle_irq_out, wake_irq_out;
    wire logic tx_desc_ready_in, tx_desc_owned_in;
    wire logic rx_desc_ready_in, rx_desc_owned_in;
    wire logic tx_frame_done_in, tx_underflow_in, tx_jabber_in, tx_early_in;
    wire logic rx_frame_done_in, rx_frame_seen_in, rx_overflow_in;
    wire logic rx_watchdog_in, rx_early_in;
    wire logic idle_event_in, ts_event_in, counter_event_in;
    wire logic power_mgmt_event_in;
    wire logic [2:0] irqs = {idle_irq_out, main_irq_out, wake_irq_out};

    assign {rx_frame_seen_in, tx_underflow_in, rx_early_in, rx_watchdog_in,
        rx_overflow_in, rx_frame_done_in, tx_early_in, tx_jabber_in,
        tx_frame_done_in} = pl;
    assign {power_mgmt_event_in, counter_event_in, ts_event_in,
        idle_event_in} = ev;

    mpls_top u_mpls_top (.sys_clk_in, .rst_in, .avs_address_in,
        .avs_read_in, .avs_write_in, .avs_writedata_in, .avs_byteenable_in,
        .avs_readdata_out, .avs_waitrequest_out, .tx_run_in,
        .tx_desc_ready_in, .tx_desc_owned_in, .tx_next_ptr_in,
        .tx_frame_done_in, .tx_underflow_in, .tx_jabber_in, .tx_early_in,
        .tx_fetch_out, .tx_desc_addr_out, .rx_run_in, .rx_desc_ready_in,
        .rx_desc_owned_in, .rx_next_ptr_in, .rx_frame_done_in,
        .rx_frame_seen_in, .rx_overflow_in, .rx_watchdog_in, .rx_early_in,
        .rx_fetch_out, .rx_desc_addr_out, .bus_error_in,
        .bus_error_kind_in, .idle_event_in, .ts_event_in,
        .counter_event_in, .power_mgmt_event_in, .main_irq_out,
        .idle_irq_out, .wake_irq_out);
    mpls_desc_mem u_tx_mem (.sys_clk_in, .rst_in, .fetch_in(tx_fetch_out),
        .owned_in(tx_own), .lag_in(lag), .ready_out(tx_desc_ready_in),
        .owned_out(tx_desc_owned_in));
    mpls_desc_mem u_rx_mem (.sys_clk_in, .rst_in, .fetch_in(rx_fetch_out),
        .owned_in(rx_own), .lag_in(lag), .ready_out(rx_desc_ready_in),
        .owned_out(rx_desc_owned_in));

    initial begin
        forever #2.5 sys_clk_in = ~sys_clk_in;
    end

    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h got %h", nm, e, g);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input logic w, logic [12:0] a,
        logic [31:0] d = 32'h0000_0000);
        int n = 0;
        @(posedge sys_clk_in);
        avs_read_in <= !w;
        avs_write_in <= w;
        avs_address_in <= a;
        avs_writedata_in <= d;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 40);
        q = avs_readdata_out;
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
        if (avs_waitrequest_out !== 1'b0) begin
            err_count++;
            test_done();
        end
    endtask

    // Poll status until the field settles
    task automatic expect_st(input logic [31:0] m, e);
        int n = 0;
        do begin
            bus(1'b0, ST);
            n++;
        end while ((q & m) !== e && n < 20);
        chk("status", e, q & m);
    endtask

    task automatic chk_irq(input logic [2:0] e);
        int n = 0;
        while (irqs !== e && n < 10) begin
            @(posedge sys_clk_in);
            n++;
        end
        chk("irqs", {29'h0, e}, {29'h0, irqs});
    endtask

    task automatic pulse(input logic [8:0] v);
        @(posedge sys_clk_in);
        pl <= v;
        @(posedge sys_clk_in);
        pl <= 9'h000;
    endtask

    initial begin
        repeat (20000) @(posedge sys_clk_in);
        err_count++;
        test_done();
    end

    initial begin
        repeat (12) @(posedge sys_clk_in);
        rst_in <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            bus(1'b0, OFS[i]);
            chk("reset", 32'h0000_0000, q);
        end
        bus(1'b1, 13'h1000, 32'hffff_ffff);
        bus(1'b0, 13'h1000);
        chk("unmapped", 32'h0000_0000, q);
        bus(1'b1, OFS[2], 32'h1234_5678);
        bus(1'b0, OFS[2]);
        chk("rx base", 32'h1234_5678, q);
        bus(1'b1, OFS[3], 32'h8765_4320);
        bus(1'b0, OFS[3]);
        chk("tx base", 32'h8765_4320, q);
        tx_run_in <= 1'b1;
        expect_st(32'h0071_8004, 32'h0060_0004);
        chk("tx addr", 32'h8765_4320, tx_desc_addr_out);
        tx_own <= 1'b1;
        bus(1'b1, OFS[0], 32'h0000_0000);
        expect_st(32'h0070_0000, 32'h0030_0000);
        bus(1'b0, OFS[0]);
        chk("tx poll", 32'h0000_0000, q);
        expect_st(32'h0000_0004, 32'h0000_0004);
        bus(1'b1, ST, 32'h0000_0004);
        expect_st(32'h0000_0004, 32'h0000_0000);
        pulse(9'h080);
        expect_st(32'h0070_0020, 32'h0060_0020);
        bus(1'b1, OFS[0], 32'h5a5a_5a5a);
        expect_st(32'h0070_0000, 32'h0030_0000);
        lag <= 4'h3;
        rx_run_in <= 1'b1;
        expect_st(32'h000e_0080, 32'h0008_0080);
        chk("rx addr", 32'h1234_5678, rx_desc_addr_out);
        bus(1'b1, ST, 32'h0000_0080);
        bus(1'b1, OFS[1], 32'hffff_ffff);
        expect_st(32'h000e_0080, 32'h0008_0080);
        rx_own <= 1'b1;
        bus(1'b1, OFS[1], 32'h0000_0001);
        expect_st(32'h000e_0080, 32'h0006_0080);
        bus(1'b1, EN, 32'h0000_00a1);
        expect_st(32'h0001_80a0, 32'h0000_80a0);
        chk_irq(3'h2);
        pulse(9'h001);
        expect_st(32'h0001_8001, 32'h0001_8001);
        chk("tx addr", 32'h0000_2000, tx_desc_addr_out);
        bus(1'b1, ST, 32'h0001_e7ff);
        bus(1'b1, ST, 32'h0001_e7ff);
        expect_st(32'h0001_ffff, 32'h0000_0000);
        chk_irq(3'h0);
        bus(1'b1, EN, 32'h0000_0000);
        bus(1'b1, ST, 32'hfffe_1800);
        expect_st(32'hfffe_1800, 32'h0036_0000);
        for (int i = 0; i < 4; i++) begin
            ev <= 4'h1 << i;
            expect_st(32'h7800_0000, 32'h1 << EVB[i]);
            chk_irq(EVI[i]);
            ev <= 4'h0;
            expect_st(32'h7800_0000, 32'h0000_0000);
            chk_irq(3'h0);
        end
        for (int i = 0; i < 7; i++) begin
            pulse(9'h001 << i);
            expect_st(32'h0001_ffff, 32'h1 << FB[i]);
            bus(1'b1, ST, 32'h1 << FB[i]);
        end
        tx_run_in <= 1'b0;
        rx_run_in <= 1'b0;
        expect_st(32'h007e_0102, 32'h0000_0102);
        bus(1'b1, ST, 32'h0000_0102);
        @(posedge sys_clk_in);
        bus_error_kind_in <= 3'h5;
        bus_error_in <= 1'b1;
        @(posedge sys_clk_in);
        bus_error_in <= 1'b0;
        expect_st(32'h0380_2000, 32'h0280_2000);
        test_done();
    end
endmodule
`default_nettype wire
